// [hw/bpad_top.sv]
`timescale 1ns/10ps
module bpad_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                cmp1_in,
   input  wire logic                cmp2_in,
   input  wire logic                fault_in_n,
   input  wire logic                period_start,
   input  wire logic [bpad_pkg::BPAD_LANES-1:0] pwm_raw,
   input  wire logic                sleep_in,
   output logic                     bridge_out_a,
   output logic                     bridge_out_a_oe,
   output logic                     bridge_out_b,
   output logic                     bridge_out_b_oe,
   output logic                     bridge_out_c,
   output logic                     bridge_out_c_oe,
   output logic                     bridge_out_d,
   output logic                     bridge_out_d_oe
);
   import bpad_pkg::*;

   typedef struct packed {
      logic [7:0]                       dbr;
      logic [7:0]                       asd;
      logic [BPAD_OCTL_W-1:0]           octl;
      logic                             safe;
      logic [BPAD_LANES-1:0]            raw_prev;
      logic [BPAD_LANES-1:0][6:0]       cnt;
      logic [BPAD_LANES-1:0]            out;
      logic [BPAD_LANES-1:0]            oe;
      logic                             pready;
      logic                             pslverr;
      logic [31:0]                      prdata;
   } bpad_state_t;

   bpad_state_t s_q;
   bpad_state_t s_d;

   // selected shutdown condition from the source selector
   function automatic logic bpad_cond(input logic [2:0] sel,
                                      input logic c1,
                                      input logic c2,
                                      input logic f_n);
      logic c;
      c = 1'b0;
      unique case (sel)
         BPAD_SRC_OFF:  c = 1'b0;
         BPAD_SRC_C1:   c = c1;
         BPAD_SRC_C2:   c = c2;
         BPAD_SRC_C12:  c = c1 | c2;
         BPAD_SRC_F:    c = ~f_n;
         BPAD_SRC_FC1:  c = ~f_n | c1;
         BPAD_SRC_FC2:  c = ~f_n | c2;
         BPAD_SRC_FC12: c = ~f_n | c1 | c2;
      endcase
      return c;
   endfunction

   // safe-state field decode: returns {drive, level}
   function automatic logic [1:0] bpad_safe(input logic [1:0] fld);
      return {~fld[1], fld[0]};
   endfunction

   logic       cond;
   logic       wr_acc;
   logic       rd_acc;
   logic       wr_asd;
   logic       flag_wr1;
   logic       flag_wr0;
   logic [2:0] src_sel;

   // live condition and accepted bus accesses
   assign src_sel  = s_q.asd[BPAD_SRC_MSB:BPAD_SRC_LSB];
   assign cond     = bpad_cond(src_sel, cmp1_in, cmp2_in, fault_in_n);
   assign wr_acc   = psel & penable & s_q.pready & pwrite;
   assign rd_acc   = psel & penable & ~s_q.pready & ~pwrite;
   assign wr_asd   = wr_acc & (paddr[7:0] == BPAD_ASD_ADDR);
   assign flag_wr1 = wr_asd & pwdata[BPAD_FLAG_BIT];
   assign flag_wr0 = wr_asd & ~pwdata[BPAD_FLAG_BIT];

   // next-state logic
   always_comb begin
      logic       auto_clr;
      logic       lane_act;
      logic       rise;
      logic [1:0] sf;
      logic       pair;
      auto_clr = 1'b0;
      lane_act = 1'b0;
      rise     = 1'b0;
      sf       = 2'b00;
      pair     = 1'b0;
      s_d      = s_q;
      if (!sleep_in) begin
         // apb slave: one wait state, answer in the second access cycle
         s_d.pready  = psel & penable & ~s_q.pready;
         s_d.pslverr = 1'b0;
         if (psel && penable && !s_q.pready) begin
            s_d.prdata = 32'h0000_0000;
            unique case (paddr[7:0])
               BPAD_DBR_ADDR:  s_d.prdata = {24'h00_0000, s_q.dbr};
               BPAD_ASD_ADDR:  s_d.prdata = {24'h00_0000, s_q.asd};
               BPAD_OCTL_ADDR: s_d.prdata = {26'h000_0000, s_q.octl};
               BPAD_STAT_ADDR: s_d.prdata = {29'h0000_0000, s_q.safe,
                                             cond, s_q.asd[BPAD_FLAG_BIT]};
               default:        s_d.pslverr = 1'b1;
            endcase
            if (!rd_acc) s_d.prdata = 32'h0000_0000;
         end
         if (wr_acc && paddr[7:0] == BPAD_DBR_ADDR) s_d.dbr = pwdata[7:0];
         if (wr_acc && paddr[7:0] == BPAD_OCTL_ADDR) begin
            s_d.octl = pwdata[BPAD_OCTL_W-1:0];
         end
         if (wr_asd) s_d.asd[BPAD_SRC_MSB:0] = pwdata[BPAD_SRC_MSB:0];
         // shutdown event flag: hardware set wins over every clear
         auto_clr = s_q.dbr[BPAD_RESTART_BIT] & ~cond;
         if (cond) begin
            s_d.asd[BPAD_FLAG_BIT] = 1'b1;
         end else if (flag_wr1) begin
            s_d.asd[BPAD_FLAG_BIT] = 1'b1;
         end else if (flag_wr0 || auto_clr) begin
            s_d.asd[BPAD_FLAG_BIT] = 1'b0;
         end
         // safe hold: released only at a period boundary
         s_d.safe = s_d.asd[BPAD_FLAG_BIT] |
                    (s_q.safe & ~period_start);
         // per-lane deadband and output levels
         for (int i = 0; i < BPAD_LANES; i++) begin
            pair = i[0];                                       // 0: a/c, 1: b/d
            rise = pwm_raw[i] & ~s_q.raw_prev[i];
            s_d.raw_prev[i] = pwm_raw[i];
            if (rise) begin
               s_d.cnt[i] = s_q.dbr[BPAD_DBC_MSB:0];
            end else if (!pwm_raw[i]) begin
               s_d.cnt[i] = 7'h00;
            end else if (s_q.cnt[i] != 7'h00) begin
               s_d.cnt[i] = s_q.cnt[i] - 7'h01;
            end
            lane_act = pwm_raw[i] & (s_d.cnt[i] == 7'h00);
            sf = pair ? bpad_safe(s_d.asd[BPAD_BD_MSB:BPAD_BD_LSB])
                      : bpad_safe(s_d.asd[BPAD_AC_MSB:BPAD_AC_LSB]);
            if (s_d.safe) begin
               s_d.out[i] = sf[0];
               s_d.oe[i]  = sf[1] & s_d.octl[BPAD_PINEN_LSB+i];
            end else begin
               s_d.out[i] = lane_act ^ s_d.octl[pair];
               s_d.oe[i]  = s_d.octl[BPAD_PINEN_LSB+i];
            end
         end
      end
   end

   // single state register; sleep leaves it untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign prdata          = s_q.prdata;
   assign pready          = s_q.pready;
   assign pslverr         = s_q.pslverr;
   assign bridge_out_a    = s_q.out[0];
   assign bridge_out_a_oe = s_q.oe[0];
   assign bridge_out_b    = s_q.out[1];
   assign bridge_out_b_oe = s_q.oe[1];
   assign bridge_out_c    = s_q.out[2];
   assign bridge_out_c_oe = s_q.oe[2];
   assign bridge_out_d    = s_q.out[3];
   assign bridge_out_d_oe = s_q.oe[3];

   // checks on flag, hold and output behaviour
   a_flag_on_cond: assert property (@(posedge pclk) disable iff (!presetn)
      cond && !sleep_in |=> s_q.asd[BPAD_FLAG_BIT] && s_q.safe)
      else $error("flag or hold missing after shutdown condition");

   a_zero_sel_off: assert property (@(posedge pclk) disable iff (!presetn)
      src_sel == BPAD_SRC_OFF |-> !cond)
      else $error("condition seen with sources disabled");

   a_fault_low: assert property (@(posedge pclk) disable iff (!presetn)
      src_sel[2] && !fault_in_n |-> cond)
      else $error("low fault input not treated as shutdown");

   a_hold_period: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.safe && !period_start |=> s_q.safe)
      else $error("hold released away from a period boundary");

   a_resume_edge: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(s_q.safe) |-> $past(period_start)
                          && !s_q.asd[BPAD_FLAG_BIT])
      else $error("resume not at a period start");

   a_write_block: assert property (@(posedge pclk) disable iff (!presetn)
      flag_wr0 && cond && !sleep_in |=> s_q.asd[BPAD_FLAG_BIT])
      else $error("flag cleared while condition active");

   a_auto_clear: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.asd[BPAD_FLAG_BIT] && s_q.dbr[BPAD_RESTART_BIT] && !cond
      && !flag_wr1 && !sleep_in |=> !s_q.asd[BPAD_FLAG_BIT])
      else $error("auto restart did not clear flag");

   a_manual_hold: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.asd[BPAD_FLAG_BIT] && !s_q.dbr[BPAD_RESTART_BIT]
      && !flag_wr0 |=> s_q.asd[BPAD_FLAG_BIT])
      else $error("flag cleared without software");

   a_force_write: assert property (@(posedge pclk) disable iff (!presetn)
      flag_wr1 && !sleep_in |=> s_q.asd[BPAD_FLAG_BIT] ##0 s_q.safe)
      else $error("software force did not shut down");

   a_ac_safe_lvl: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.safe |-> bridge_out_a_oe == (!s_q.asd[BPAD_AC_MSB]
                    && s_q.octl[BPAD_PINEN_LSB])
                   && bridge_out_a == s_q.asd[BPAD_AC_LSB])
      else $error("pin a not at its safe level");

   a_bd_safe_lvl: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.safe |-> bridge_out_d_oe == (!s_q.asd[BPAD_BD_MSB]
                    && s_q.octl[BPAD_PINEN_LSB+3])
                   && bridge_out_d == s_q.asd[BPAD_BD_LSB])
      else $error("pin d not at its safe level");

   a_deadband_lo: assert property (@(posedge pclk) disable iff (!presetn)
      !s_q.safe && s_q.cnt[0] != 7'h00 |->
      bridge_out_a == s_q.octl[0])
      else $error("pin a active during deadband");

   a_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
      sleep_in |=> $stable(s_q.out) && $stable(s_q.oe))
      else $error("outputs changed during sleep");

   // bus handshake: one wait state, one-cycle answer
   a_pready_pulse: assert property (@(posedge pclk)
      disable iff (!presetn) pready && !sleep_in |=> !pready)
      else $error("ready held longer than one cycle");

   a_pready_wait: assert property (@(posedge pclk)
      disable iff (!presetn)
      psel && penable && !pready && !sleep_in |=> pready)
      else $error("access phase not answered");

   a_idle_quiet: assert property (@(posedge pclk)
      disable iff (!presetn) !psel && !sleep_in |=> !pready)
      else $error("ready without a selected transfer");

   a_err_no_data: assert property (@(posedge pclk)
      disable iff (!presetn) pready && pslverr |-> prdata == 32'h0)
      else $error("error answer carries data");

   a_write_dbr: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_acc && paddr[7:0] == BPAD_DBR_ADDR && !sleep_in
      |=> s_q.dbr == $past(pwdata[7:0]))
      else $error("deadband register write lost");

   a_sleep_regs: assert property (@(posedge pclk)
      disable iff (!presetn)
      sleep_in |=> $stable(s_q.asd) && $stable(s_q.dbr))
      else $error("registers changed during sleep");

   a_flag_keeps: assert property (@(posedge pclk)
      disable iff (!presetn) s_q.asd[BPAD_FLAG_BIT] |-> s_q.safe)
      else $error("flag set without output hold");

   a_hold_rise: assert property (@(posedge pclk)
      disable iff (!presetn) $rose(s_q.safe) |-> s_q.asd[BPAD_FLAG_BIT])
      else $error("hold entered without event flag");

   a_off_no_set: assert property (@(posedge pclk)
      disable iff (!presetn)
      src_sel == BPAD_SRC_OFF && !flag_wr1 && !s_q.asd[BPAD_FLAG_BIT]
      && !sleep_in |=> !s_q.asd[BPAD_FLAG_BIT])
      else $error("flag set with sources disabled");

   a_cmp1_only: assert property (@(posedge pclk)
      disable iff (!presetn) src_sel == BPAD_SRC_C1 |-> cond == cmp1_in)
      else $error("comparator one selection wrong");

   a_fault_only: assert property (@(posedge pclk)
      disable iff (!presetn) src_sel == BPAD_SRC_F |-> cond == !fault_in_n)
      else $error("fault-only selection wrong");

   a_b_safe_lvl: assert property (@(posedge pclk)
      disable iff (!presetn)
      s_q.safe |-> bridge_out_b_oe == (!s_q.asd[BPAD_BD_MSB]
                    && s_q.octl[BPAD_PINEN_LSB+1])
                   && bridge_out_b == s_q.asd[BPAD_BD_LSB])
      else $error("pin b not at its safe level");

   a_c_safe_lvl: assert property (@(posedge pclk)
      disable iff (!presetn)
      s_q.safe |-> bridge_out_c_oe == (!s_q.asd[BPAD_AC_MSB]
                    && s_q.octl[BPAD_PINEN_LSB+2])
                   && bridge_out_c == s_q.asd[BPAD_AC_LSB])
      else $error("pin c not at its safe level");

   a_deadband_d: assert property (@(posedge pclk)
      disable iff (!presetn)
      !s_q.safe && s_q.cnt[3] != 7'h00 |-> bridge_out_d == s_q.octl[1])
      else $error("pin d active during deadband");

   a_pin_dir_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !s_q.octl[BPAD_PINEN_LSB] |-> !bridge_out_a_oe)
      else $error("pin a driven while set as input");

   a_pin_dir_b: assert property (@(posedge pclk)
      disable iff (!presetn)
      !s_q.octl[BPAD_PINEN_LSB+1] |-> !bridge_out_b_oe)
      else $error("pin b driven while set as input");

   a_norm_oe_d: assert property (@(posedge pclk)
      disable iff (!presetn)
      !s_q.safe |-> bridge_out_d_oe == s_q.octl[BPAD_PINEN_LSB+3])
      else $error("pin d drive enable wrong in normal run");
endmodule

// [hw/bpad_pkg.sv]
package bpad_pkg;
   // register byte addresses
   localparam logic [7:0] BPAD_DBR_ADDR  = 8'h00; // deadband / restart ctrl
   localparam logic [7:0] BPAD_ASD_ADDR  = 8'h04; // auto-shutdown ctrl
   localparam logic [7:0] BPAD_OCTL_ADDR = 8'h08; // polarity and pin enables
   localparam logic [7:0] BPAD_STAT_ADDR = 8'h0c; // live status, read only
   // field positions
   localparam int BPAD_RESTART_BIT = 7;  // auto_restart_en in dbr
   localparam int BPAD_DBC_MSB     = 6;  // deadband_count [6:0]
   localparam int BPAD_FLAG_BIT    = 7;  // shutdown_event_flag in asd
   localparam int BPAD_SRC_MSB     = 6;  // shutdown_source_sel [6:4]
   localparam int BPAD_SRC_LSB     = 4;
   localparam int BPAD_AC_MSB      = 3;  // pair_ac_safe_state [3:2]
   localparam int BPAD_AC_LSB      = 2;
   localparam int BPAD_BD_MSB      = 1;  // pair_bd_safe_state [1:0]
   localparam int BPAD_BD_LSB      = 0;
   localparam int BPAD_POL_MSB     = 1;  // output_polarity_sel [1:0]
   localparam int BPAD_PINEN_LSB   = 2;  // pin_direction_bits [5:2]
   localparam int BPAD_OCTL_W      = 6;
   // reset values
   localparam logic [7:0] BPAD_DBR_RST  = 8'h00;
   localparam logic [7:0] BPAD_ASD_RST  = 8'h00;
   localparam logic [5:0] BPAD_OCTL_RST = 6'h00;
   // shutdown source selector codes
   localparam logic [2:0] BPAD_SRC_OFF   = 3'h0;
   localparam logic [2:0] BPAD_SRC_C1    = 3'h1;
   localparam logic [2:0] BPAD_SRC_C2    = 3'h2;
   localparam logic [2:0] BPAD_SRC_C12   = 3'h3;
   localparam logic [2:0] BPAD_SRC_F     = 3'h4;
   localparam logic [2:0] BPAD_SRC_FC1   = 3'h5;
   localparam logic [2:0] BPAD_SRC_FC2   = 3'h6;
   localparam logic [2:0] BPAD_SRC_FC12  = 3'h7;
   // bridge lanes: a, b, c, d
   localparam int BPAD_LANES = 4;
endpackage

// [testbench/bpad_partner.sv]
`timescale 1ns/10ps
module bpad_partner #(
   parameter int PERIOD = 40,
   parameter int DUTY   = 20
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       hold,
   input  wire logic [2:0] src_req,
   output logic            cmp1_in,
   output logic            cmp2_in,
   output logic            fault_in_n,
   output logic            period_start,
   output logic [3:0]      pwm_raw
);
   logic [7:0] cnt_q;
   // period timer, frozen while the device sleeps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
      end else if (!hold) begin
         cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      end
   end
   // period boundary pulse and scheduled active window
   assign period_start = (cnt_q == 8'h00) && !hold;
   assign pwm_raw      = {4{cnt_q < 8'(DUTY)}};
   // comparators go high over threshold, fault line pulled low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp1_in    <= 1'b0;
         cmp2_in    <= 1'b0;
         fault_in_n <= 1'b1;
      end else begin
         cmp1_in    <= src_req[0];
         cmp2_in    <= src_req[1];
         fault_in_n <= ~src_req[2];
      end
   end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
   import bpad_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, sleep_in, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, cmp1_in, cmp2_in, fault_in_n, period_start;
   logic [3:0]  pwm_raw, sv;
   logic [2:0]  src_req;
   logic        a, a_oe, b, b_oe, c, c_oe, d, d_oe;
   int          bad_count, checks, k, nn;

   bpad_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp1_in(cmp1_in), .cmp2_in(cmp2_in), .fault_in_n(fault_in_n),
      .period_start(period_start), .pwm_raw(pwm_raw), .sleep_in(sleep_in),
      .bridge_out_a(a), .bridge_out_a_oe(a_oe), .bridge_out_b(b),
      .bridge_out_b_oe(b_oe), .bridge_out_c(c), .bridge_out_c_oe(c_oe),
      .bridge_out_d(d), .bridge_out_d_oe(d_oe));
   bpad_partner FAR (.pclk(pclk), .presetn(presetn), .hold(sleep_in),
      .src_req(src_req), .cmp1_in(cmp1_in), .cmp2_in(cmp2_in),
      .fault_in_n(fault_in_n), .period_start(period_start),
      .pwm_raw(pwm_raw));

   // clock, 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic [7:0] ad, input logic w,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
   endtask

   // wait for a period start, sampled mid-cycle
   task automatic wper();
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (period_start !== 1'b1 && n < 100);
      if (period_start !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
   endtask

   // main sequence
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      sleep_in = 0; src_req = 0; bad_count = 0; checks = 0; presetn = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(BPAD_DBR_ADDR, 0, 0); chk(rd, 32'h0);
      apb(BPAD_ASD_ADDR, 0, 0); chk(rd, 32'h0);
      apb(BPAD_OCTL_ADDR, 0, 0); chk(rd, 32'h0);
      chk({a_oe, b_oe, c_oe, d_oe}, 32'h0);
      apb(8'h10, 0, 0); chk(32'(er), 32'h1);
      $display("test reset done");
      apb(BPAD_ASD_ADDR, 1, 32'h0);
      apb(BPAD_OCTL_ADDR, 1, 32'h0);
      wper(); wper();
      apb(BPAD_OCTL_ADDR, 1, 32'h3c);
      apb(BPAD_OCTL_ADDR, 0, 0); chk(rd, 32'h3c);
      // every selector code against every single source
      for (int s = 0; s < 8; s++) begin
         for (int i = 0; i < 3; i++) begin
            apb(BPAD_ASD_ADDR, 1, {24'h0, 1'b0, s[2:0], 4'h4});
            @(posedge pclk); src_req <= 3'(1 << i);
            repeat (3) @(posedge pclk);
            apb(BPAD_ASD_ADDR, 0, 0);
            chk(32'(rd[7]), 32'(s[i]));
            if (s[i]) chk({a, a_oe, c, c_oe}, 32'hf);
            @(posedge pclk); src_req <= 3'h0;
            repeat (2) @(posedge pclk);
         end
      end
      apb(BPAD_ASD_ADDR, 1, 32'h0);
      $display("test sources done");
      // software-forced shutdown, all safe codes, inverted polarity
      apb(BPAD_OCTL_ADDR, 1, 32'h3f);
      for (int v = 0; v < 4; v++) begin
         apb(BPAD_ASD_ADDR, 1, {24'h0, 1'b1, 3'h0, v[1:0], v[1:0]});
         repeat (2) @(posedge pclk);
         chk({a & a_oe, a_oe, b & b_oe, b_oe, c & c_oe, c_oe, d & d_oe, d_oe},
             32'({4{v[0] & ~v[1], ~v[1]}}));
         apb(BPAD_ASD_ADDR, 1, 32'h0);
      end
      apb(BPAD_OCTL_ADDR, 1, 32'h3c);
      $display("test safe states done");
      // level cause, ignored clear, auto restart, resume at boundary
      apb(BPAD_DBR_ADDR, 1, 32'h80);
      apb(BPAD_ASD_ADDR, 1, 32'h14);
      @(posedge pclk); src_req <= 3'h1;
      wper();
      apb(BPAD_ASD_ADDR, 1, 32'h14);
      apb(BPAD_ASD_ADDR, 0, 0); chk(32'(rd[7]), 32'h1);
      apb(BPAD_STAT_ADDR, 0, 0); chk(rd, 32'h7);
      @(posedge pclk); src_req <= 3'h0;
      repeat (3) @(posedge pclk);
      apb(BPAD_ASD_ADDR, 0, 0); chk(32'(rd[7]), 32'h0);
      repeat (8) @(posedge pclk);
      chk({a, a_oe}, 32'h3);
      wper(); repeat (25) @(negedge pclk);
      chk({a, a_oe}, 32'h1);
      // restart disabled: flag waits for software
      apb(BPAD_DBR_ADDR, 1, 32'h0);
      @(posedge pclk); src_req <= 3'h1;
      repeat (3) @(posedge pclk); src_req <= 3'h0;
      repeat (3) @(posedge pclk);
      apb(BPAD_ASD_ADDR, 0, 0); chk(32'(rd[7]), 32'h1);
      apb(BPAD_ASD_ADDR, 1, 32'h0);
      apb(BPAD_ASD_ADDR, 0, 0); chk(32'(rd[7]), 32'h0);
      $display("test restart done");
      // dead band: zero, short and beyond the duty time
      for (int j = 0; j < 3; j++) begin
         nn = (j == 0) ? 0 : (j == 1) ? 5 : 30;
         apb(BPAD_DBR_ADDR, 1, 32'(nn));
         wper(); k = 0;
         do begin
            @(negedge pclk);
            k++;
         end while (a !== 1'b1 && k < 40);
         chk(32'(k), (nn < 20) ? 32'(nn + 1) : 32'd40);
      end
      apb(BPAD_DBR_ADDR, 1, 32'h0);
      apb(BPAD_OCTL_ADDR, 1, 32'h3d);
      wper(); repeat (3) @(negedge pclk);
      chk({a, c, b, d}, 32'h3);
      $display("test deadband done");
      // sleep freezes pins while comparator one rises with all sources deselected
      @(posedge pclk); sleep_in <= 1'b1; src_req <= 3'h1;
      @(posedge pclk); sv = {a, b, c, d};
      repeat (6) @(posedge pclk);
      chk({a, b, c, d}, {28'h0, sv});
      sleep_in <= 1'b0; src_req <= 3'h0;
      $display("test sleep done");
      print_verdict();
   end
endmodule
